// *** hw/msh_pkg.sv ***
package msh_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 40;
   localparam int OSC_PERIOD_NS  = 1000;        // sequencer oscillator tick
   localparam int OSC_DIV_CYC    = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MEAS_LN_NS     = 872000;      // low-noise conversion, longest
   localparam int MEAS_LP_NS     = 253000;      // low-power conversion, longest
   localparam int CONT_PERIOD_NS = 100000000;   // continuous repeat gap
   localparam int MEAS_LN_TICKS  = MEAS_LN_NS / OSC_PERIOD_NS;
   localparam int MEAS_LP_TICKS  = MEAS_LP_NS / OSC_PERIOD_NS;
   localparam int CONT_TICKS     = CONT_PERIOD_NS / OSC_PERIOD_NS;
   localparam int FAST_LIMIT_NS  = 10000;       // clock period of 100 kHz
   localparam int FAST_LIMIT_CYC = FAST_LIMIT_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 17;
   localparam int PER_W          = 9;

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int              AXES         = 3;
   localparam int              DATA_W       = 16;
   localparam int              EVSEL_DATA_READY_FLAG   = 0;
   localparam int              EVSEL_THR    = 1;
   localparam logic [1:0]      EVSEL_RST    = 2'h0;
   localparam logic            RANGE_RST    = 1'b0;
   localparam logic            DRIVE_RST    = 1'b0;
   localparam logic [15:0]     THR_RST      = 16'h7FFF;
   localparam logic [15:0]     MEAS_RST     = 16'h0000;

   typedef enum logic [1:0] {
      MODE_PDN    = 2'h0,
      MODE_SINGLE = 2'h1,
      MODE_CONT   = 2'h2
   } msh_mode_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_MEAS = 3'h2,
      SEQ_WAIT = 3'h4
   } msh_seq_state_t;

   // signed compare of one axis against its switch threshold
   function automatic logic msh_exceeds(input logic [15:0] val, input logic [15:0] thr);
      msh_exceeds = $signed(val) > $signed(thr);
   endfunction : msh_exceeds
endpackage : msh_pkg

// *** hw/msh_seq_if.sv ***
`timescale 1ns/1ps
interface msh_seq_if;
   msh_pkg::msh_mode_t mode;       // operating mode from control
   logic               low_power;  // drive setting
   logic               done;       // conversion finished, one cycle
   logic               busy;       // sensor driven

   modport ctl (output mode, output low_power, input done, input busy);
   modport seq (input mode, input low_power, output done, output busy);
endinterface : msh_seq_if

// *** hw/msh_sync.sv ***
`timescale 1ns/1ps
module msh_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,  // system clock
   input  wire logic         rst,  // sync reset
   input  wire logic [W-1:0] d,    // asynchronous levels
   output logic      [W-1:0] q     // synchronised levels
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s1_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // first stage feeds only the second
   always_comb begin
      s1_next = d;
      q_next  = s1_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= INIT;
         q_reg  <= INIT;
      end else begin
         s1_reg <= s1_next;
         q_reg  <= q_next;
      end
   end

   assign q = q_reg;
endmodule : msh_sync

// *** hw/msh_seq.sv ***
`timescale 1ns/1ps
module msh_seq #(
   parameter logic [16:0] MEAS_LN_TICKS = 17'(msh_pkg::MEAS_LN_TICKS),
   parameter logic [16:0] MEAS_LP_TICKS = 17'(msh_pkg::MEAS_LP_TICKS),
   parameter logic [16:0] CONT_TICKS    = 17'(msh_pkg::CONT_TICKS)
) (
   input  wire logic clk,  // system clock
   input  wire logic clr,  // register clear
   msh_seq_if.seq    sif   // control side
);
   localparam logic [7:0] OSC_LAST = 8'(msh_pkg::OSC_DIV_CYC - 1);

   msh_pkg::msh_seq_state_t state_reg, state_next;
   logic [7:0]              osc_reg, osc_next;
   logic [16:0]             cnt_reg, cnt_next;
   logic                    tick;
   logic [16:0]             meas_len;

   // ---------------------------------------------------------------
   // oscillator tick and conversion sequencer
   // ---------------------------------------------------------------
   assign tick     = (osc_reg == OSC_LAST);
   assign meas_len = sif.low_power ? MEAS_LP_TICKS : MEAS_LN_TICKS;
   assign sif.busy = (state_reg == msh_pkg::SEQ_MEAS);

   // counts are in oscillator ticks, never in bus clock edges
   always_comb begin
      osc_next   = tick ? 8'h00 : osc_reg + 8'h01;
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sif.done   = 1'b0;
      case (state_reg)
         msh_pkg::SEQ_IDLE: begin
            if (sif.mode != msh_pkg::MODE_PDN) begin
               state_next = msh_pkg::SEQ_MEAS;
               cnt_next   = meas_len;
            end
         end
         msh_pkg::SEQ_MEAS: begin
            if (sif.mode == msh_pkg::MODE_PDN) begin
               state_next = msh_pkg::SEQ_IDLE;
            end else if (tick) begin
               if (cnt_reg <= 17'h00001) begin
                  sif.done = 1'b1;
                  if (sif.mode == msh_pkg::MODE_CONT) begin
                     state_next = msh_pkg::SEQ_WAIT;
                     cnt_next   = CONT_TICKS;
                  end else begin
                     state_next = msh_pkg::SEQ_IDLE;
                  end
               end else begin
                  cnt_next = cnt_reg - 17'h00001;
               end
            end
         end
         msh_pkg::SEQ_WAIT: begin
            if (sif.mode != msh_pkg::MODE_CONT) begin
               state_next = msh_pkg::SEQ_IDLE;
            end else if (tick) begin
               if (cnt_reg <= 17'h00001) begin
                  state_next = msh_pkg::SEQ_MEAS;
                  cnt_next   = meas_len;
               end else begin
                  cnt_next = cnt_reg - 17'h00001;
               end
            end
         end
         default: state_next = msh_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (clr) begin
         state_reg <= msh_pkg::SEQ_IDLE;
         osc_reg   <= 8'h00;
         cnt_reg   <= 17'h00000;
      end else begin
         state_reg <= state_next;
         osc_reg   <= osc_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_meas_start;
      (state_reg == msh_pkg::SEQ_IDLE) ##1 (state_reg == msh_pkg::SEQ_MEAS);
   endsequence

   a_meas_start_len: assert property (@(posedge clk) disable iff (clr)
      s_meas_start |-> (cnt_reg == $past(meas_len)))
      else $error("conversion loaded wrong length");
   a_done_in_meas: assert property (@(posedge clk) disable iff (clr)
      sif.done |-> (state_reg == msh_pkg::SEQ_MEAS) && tick)
      else $error("done outside a conversion tick");
endmodule : msh_seq

// *** hw/msh_top.sv ***
`timescale 1ns/1ps
module msh_top #(
   parameter logic [16:0] MEAS_LN_TICKS = 17'(msh_pkg::MEAS_LN_TICKS),
   parameter logic [16:0] MEAS_LP_TICKS = 17'(msh_pkg::MEAS_LP_TICKS),
   parameter logic [16:0] CONT_TICKS    = 17'(msh_pkg::CONT_TICKS)
) (
   input  wire logic        CLK_SYS,          // 25 MHz clock
   input  wire logic        SYS_RST,          // sync reset, high
   input  wire logic        RESET_N_PIN,      // register reset pin, low
   input  wire logic        SPI_SELECT_N,     // chip select pin
   input  wire logic        ADDR_SELECT_PIN,  // address select pin
   input  wire logic        SERIAL_CLOCK_IN,  // bus clock pin
   input  wire logic        SO_DATA,          // shift-out bit from serial engine
   input  wire logic        SDA_PULL,         // serial engine pulls data low
   input  wire logic        CFG_WR,           // config write strobe
   input  wire logic [1:0]  CFG_MODE,         // operation mode code
   input  wire logic        CFG_WIDE_RANGE,   // 1 = wide range
   input  wire logic        CFG_LOW_POWER,    // 1 = low-power drive
   input  wire logic [1:0]  CFG_EVENT_SEL,    // bit0 ready, bit1 threshold
   input  wire logic [15:0] CFG_THR_X,        // x switch threshold
   input  wire logic [15:0] CFG_THR_Y,        // y switch threshold
   input  wire logic [15:0] CFG_THR_Z,        // z switch threshold
   input  wire logic        DATA_READ,        // host read, clears ready
   input  wire logic [15:0] ADC_X,            // converter x result
   input  wire logic [15:0] ADC_Y,            // converter y result
   input  wire logic [15:0] ADC_Z,            // converter z result
   input  wire logic        ADC_OVF,          // converter overflow
   output logic             EVENT_OUT,        // push-pull event, high
   output logic             EVENT_OUT_OPEN_DRAIN_O,  // open-drain level
   output logic             EVENT_OUT_OPEN_DRAIN_OE, // pulls low when high
   output logic             SO_O,             // serial data out
   output logic             SO_OE,            // serial out driven
   output logic             SDA_O,            // data line level
   output logic             SDA_OE,           // data line pulled low
   output logic             I2C_MODE,         // two-wire bus selected
   output logic             SLAVE_ADDR_SEL,   // address select bit
   output logic             BUS_FAST,         // fast speed detected
   output logic             SPI_SAMPLE,       // rising edge, input sample
   output logic             SPI_SHIFT,        // falling edge, output shift
   output logic [15:0]      MEAS_X,           // x result
   output logic [15:0]      MEAS_Y,           // y result
   output logic [15:0]      MEAS_Z,           // z result
   output logic             OVERFLOW,         // last conversion overflowed
   output logic [2:0]       SWITCH_BITS,      // per-axis threshold state
   output logic             DATA_READY,       // data ready flag
   output logic             THRESHOLD_STATE,  // threshold crossing state
   output logic [1:0]       MODE_STATE,       // current mode
   output logic             WIDE_RANGE,       // range to front end
   output logic             LOW_POWER_DRIVE,  // drive to front end
   output logic             SENSOR_ON         // sensor driven
);
   localparam logic [8:0] FAST_LIM = 9'(msh_pkg::FAST_LIMIT_CYC);
   localparam logic [8:0] PER_MAX  = 9'h1FF;

   msh_seq_if sif ();

   logic [3:0]  pins_s;
   logic        rst_n_s, sel_n_s, addr_s, sck_s, clr;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   msh_sync #(.W(4), .INIT(4'hF)) u_sync (
      .clk (CLK_SYS),
      .rst (SYS_RST),
      .d   ({RESET_N_PIN, SPI_SELECT_N, ADDR_SELECT_PIN, SERIAL_CLOCK_IN}),
      .q   (pins_s)
   );
   assign {rst_n_s, sel_n_s, addr_s, sck_s} = pins_s;
   assign clr = SYS_RST | ~rst_n_s;

   // ---------------------------------------------------------------
   // configuration group
   // ---------------------------------------------------------------
   msh_pkg::msh_mode_t mode_reg, mode_next;
   logic               range_reg, range_next, drive_reg, drive_next;
   logic [1:0]         evsel_reg, evsel_next;
   logic [15:0]        thr_reg [3];
   logic [15:0]        thr_next [3];

   // an undefined mode code falls back to power-down
   always_comb begin
      mode_next  = mode_reg;
      range_next = range_reg;
      drive_next = drive_reg;
      evsel_next = evsel_reg;
      thr_next   = thr_reg;
      if (sif.done && mode_reg == msh_pkg::MODE_SINGLE) begin
         mode_next = msh_pkg::MODE_PDN;
      end
      if (CFG_WR) begin
         case (CFG_MODE)
            2'h1:    mode_next = msh_pkg::MODE_SINGLE;
            2'h2:    mode_next = msh_pkg::MODE_CONT;
            default: mode_next = msh_pkg::MODE_PDN;
         endcase
         range_next  = CFG_WIDE_RANGE;
         drive_next  = CFG_LOW_POWER;
         evsel_next  = CFG_EVENT_SEL;
         thr_next[0] = CFG_THR_X;
         thr_next[1] = CFG_THR_Y;
         thr_next[2] = CFG_THR_Z;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (clr) begin
         mode_reg  <= msh_pkg::MODE_PDN;
         range_reg <= msh_pkg::RANGE_RST;
         drive_reg <= msh_pkg::DRIVE_RST;
         evsel_reg <= msh_pkg::EVSEL_RST;
         for (int i = 0; i < msh_pkg::AXES; i++) begin
            thr_reg[i] <= msh_pkg::THR_RST;
         end
      end else begin
         mode_reg  <= mode_next;
         range_reg <= range_next;
         drive_reg <= drive_next;
         evsel_reg <= evsel_next;
         thr_reg   <= thr_next;
      end
   end

   assign sif.mode      = mode_reg;
   assign sif.low_power = drive_reg;

   msh_seq #(
      .MEAS_LN_TICKS (MEAS_LN_TICKS),
      .MEAS_LP_TICKS (MEAS_LP_TICKS),
      .CONT_TICKS    (CONT_TICKS)
   ) u_seq (
      .clk (CLK_SYS),
      .clr (clr),
      .sif (sif.seq)
   );

   // ---------------------------------------------------------------
   // measurement and event group
   // ---------------------------------------------------------------
   logic [15:0] meas_reg [3];
   logic [15:0] meas_next [3];
   logic [2:0]  sw_reg, sw_next;
   logic        ovf_reg, ovf_next, data_ready_flag_reg, data_ready_flag_next;
   logic        thr_st_reg, thr_st_next, evt_reg, evt_next, on_reg, on_next;

   // results stay frozen between conversions; set of ready beats a read
   always_comb begin
      meas_next   = meas_reg;
      sw_next     = sw_reg;
      ovf_next    = ovf_reg;
      thr_st_next = thr_st_reg;
      data_ready_flag_next   = data_ready_flag_reg & ~DATA_READ;
      if (sif.done) begin
         meas_next[0] = ADC_X;
         meas_next[1] = ADC_Y;
         meas_next[2] = ADC_Z;
         ovf_next     = ADC_OVF;
         sw_next[0]   = msh_pkg::msh_exceeds(ADC_X, thr_reg[0]);
         sw_next[1]   = msh_pkg::msh_exceeds(ADC_Y, thr_reg[1]);
         sw_next[2]   = msh_pkg::msh_exceeds(ADC_Z, thr_reg[2]);
         thr_st_next  = |sw_next;
         data_ready_flag_next    = 1'b1;
      end
      evt_next = (evsel_reg[msh_pkg::EVSEL_DATA_READY_FLAG] & data_ready_flag_reg)
               | (evsel_reg[msh_pkg::EVSEL_THR] & thr_st_reg);
      on_next  = sif.busy;
   end

   always_ff @(posedge CLK_SYS) begin
      if (clr) begin
         for (int i = 0; i < msh_pkg::AXES; i++) begin
            meas_reg[i] <= msh_pkg::MEAS_RST;
         end
         sw_reg     <= 3'h0;
         ovf_reg    <= 1'b0;
         data_ready_flag_reg   <= 1'b0;
         thr_st_reg <= 1'b0;
         evt_reg    <= 1'b0;
         on_reg     <= 1'b0;
      end else begin
         meas_reg   <= meas_next;
         sw_reg     <= sw_next;
         ovf_reg    <= ovf_next;
         data_ready_flag_reg   <= data_ready_flag_next;
         thr_st_reg <= thr_st_next;
         evt_reg    <= evt_next;
         on_reg     <= on_next;
      end
   end

   // ---------------------------------------------------------------
   // serial pin group
   // ---------------------------------------------------------------
   logic       i2c_reg, i2c_next, addr_reg, addr_next, sck_d_reg;
   logic       fast_reg, fast_next, smp_reg, smp_next, shf_reg, shf_next;
   logic       so_reg, so_next, so_oe_reg, so_oe_next, sda_oe_reg, sda_oe_next;
   logic [8:0] per_reg, per_next;

   // bus clock is only sampled here; its edges come from the delayed copy
   always_comb begin
      i2c_next    = sel_n_s;
      addr_next   = sel_n_s & addr_s;
      so_oe_next  = ~sel_n_s;
      so_next     = ~sel_n_s & SO_DATA;
      sda_oe_next = sel_n_s & SDA_PULL;
      smp_next    = ~sel_n_s & sck_s & ~sck_d_reg;
      shf_next    = ~sel_n_s & ~sck_s & sck_d_reg;
      per_next    = (per_reg == PER_MAX) ? per_reg : per_reg + 9'h001;
      fast_next   = fast_reg;
      if (sel_n_s && sck_s && !sck_d_reg) begin
         fast_next = (per_reg < FAST_LIM);
         per_next  = 9'h000;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (clr) begin
         i2c_reg    <= 1'b1;
         addr_reg   <= 1'b0;
         so_reg     <= 1'b0;
         so_oe_reg  <= 1'b0;
         sda_oe_reg <= 1'b0;
         smp_reg    <= 1'b0;
         shf_reg    <= 1'b0;
         sck_d_reg  <= 1'b1;
         per_reg    <= PER_MAX;
         fast_reg   <= 1'b0;
      end else begin
         i2c_reg    <= i2c_next;
         addr_reg   <= addr_next;
         so_reg     <= so_next;
         so_oe_reg  <= so_oe_next;
         sda_oe_reg <= sda_oe_next;
         smp_reg    <= smp_next;
         shf_reg    <= shf_next;
         sck_d_reg  <= sck_s;
         per_reg    <= per_next;
         fast_reg   <= fast_next;
      end
   end

   // open-drain lines only ever drive zero
   logic zero_reg;
   always_ff @(posedge CLK_SYS) begin
      zero_reg <= 1'b0;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign EVENT_OUT               = evt_reg;
   assign EVENT_OUT_OPEN_DRAIN_O  = zero_reg;
   assign EVENT_OUT_OPEN_DRAIN_OE = evt_reg;
   assign SO_O            = so_reg;
   assign SO_OE           = so_oe_reg;
   assign SDA_O           = zero_reg;
   assign SDA_OE          = sda_oe_reg;
   assign I2C_MODE        = i2c_reg;
   assign SLAVE_ADDR_SEL  = addr_reg;
   assign BUS_FAST        = fast_reg;
   assign SPI_SAMPLE      = smp_reg;
   assign SPI_SHIFT       = shf_reg;
   assign MEAS_X          = meas_reg[0];
   assign MEAS_Y          = meas_reg[1];
   assign MEAS_Z          = meas_reg[2];
   assign OVERFLOW        = ovf_reg;
   assign SWITCH_BITS     = sw_reg;
   assign DATA_READY      = data_ready_flag_reg;
   assign THRESHOLD_STATE = thr_st_reg;
   assign MODE_STATE      = mode_reg;
   assign WIDE_RANGE      = range_reg;
   assign LOW_POWER_DRIVE = drive_reg;
   assign SENSOR_ON       = on_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (clr);

   sequence s_sck_rise;
      !sck_d_reg ##0 sck_s;
   endsequence

   a_data_ready_flag_on_done: assert property (sif.done |=> data_ready_flag_reg)
      else $error("ready flag missed a conversion");
   a_event_select: assert property ((evsel_reg[0] && data_ready_flag_reg) |=> evt_reg)
      else $error("ready event not forwarded");
   a_thr_event: assert property ((evsel_reg == 2'h2) |=> (evt_reg == $past(thr_st_reg)))
      else $error("threshold event wrong");
   a_open_drain_evt: assert property (EVENT_OUT_OPEN_DRAIN_OE == EVENT_OUT
      && !EVENT_OUT_OPEN_DRAIN_O)
      else $error("open-drain event mismatch");
   a_so_hiz_i2c: assert property ($rose(sel_n_s) |=> !so_oe_reg)
      else $error("serial out driven on two-wire bus");
   a_single_return: assert property ((sif.done && mode_reg == msh_pkg::MODE_SINGLE
      && !CFG_WR) |=> (mode_reg == msh_pkg::MODE_PDN))
      else $error("single mode did not return to power-down");
   a_spi_sample_edge: assert property ((s_sck_rise ##0 !sel_n_s) |=> smp_reg ##1 !smp_reg)
      else $error("rising edge not sampled");
   a_sda_open_drain: assert property (sda_oe_reg |-> i2c_reg && !SDA_O)
      else $error("data line driven high or outside two-wire mode");
   a_switch_calc: assert property (sif.done |=> (thr_st_reg == |sw_reg))
      else $error("switch state not the or of axes");
endmodule : msh_top

// *** test/msh_host_model.sv ***
`timescale 1ns/1ps
module msh_host_model (
   input  wire logic start,  // open a four-wire frame
   input  wire logic burst,  // run a two-wire clock burst
   input  wire logic fast,   // burst at the fast rate
   output logic      sel_n,  // chip select
   output logic      sk      // serial clock
);
   int half;
   // clock idles high and runs only inside a frame or a burst
   initial begin
      sel_n = 1'h1;
      sk    = 1'h1;
      forever begin
         @(posedge start or posedge burst);
         if (start) begin
            sel_n = 1'h0;
            repeat (8) begin
               #160 sk = 1'h0;
               #160 sk = 1'h1;
            end
            #160 sel_n = 1'h1;
         end else begin
            // select stays high, so the port sees a two-wire clock
            half = fast ? 1240 : 6000;
            repeat (3) begin
               #half sk = 1'h0;
               #half sk = 1'h1;
            end
         end
      end
   end
endmodule : msh_host_model

// *** test/tb_msh_top.sv ***
`timescale 1ns/1ps
module tb_msh_top;
   typedef struct {logic [1:0] s; logic l; logic [15:0] a;
                   logic o; logic [2:0] w; logic e;} msh_row_t;
   logic CLK_SYS, SYS_RST, RESET_N_PIN, ADDR_SELECT_PIN, SO_DATA, SDA_PULL, CFG_WR, DATA_READ;
   logic CFG_WIDE_RANGE, CFG_LOW_POWER, ADC_OVF, go, EVENT_OUT, EVENT_OUT_OPEN_DRAIN_O;
   logic EVENT_OUT_OPEN_DRAIN_OE, SO_O, SO_OE, SDA_O, SDA_OE, I2C_MODE, SLAVE_ADDR_SEL, BUS_FAST;
   logic SPI_SAMPLE, SPI_SHIFT, OVERFLOW, DATA_READY, THRESHOLD_STATE, WIDE_RANGE;
   logic LOW_POWER_DRIVE, SENSOR_ON, burst, fast;
   logic [1:0]  CFG_MODE, CFG_EVENT_SEL, MODE_STATE;
   logic [2:0]  SWITCH_BITS;
   logic [15:0] CFG_THR_X, CFG_THR_Y, CFG_THR_Z, ADC_X, ADC_Y, ADC_Z, MEAS_X, MEAS_Y, MEAS_Z;
   wire         SPI_SELECT_N, SERIAL_CLOCK_IN;
   int          mismatches, n_compared, cyc, edges, shifts;
   // y threshold sits higher so the axes disagree
   msh_row_t rows [5] = '{'{2'h1, 1'h0, 16'h0100, 1'h0, 3'h0, 1'h1},
      '{2'h2, 1'h1, 16'h0300, 1'h1, 3'h5, 1'h1}, '{2'h2, 1'h0, 16'hFF00, 1'h0, 3'h0, 1'h0},
      '{2'h0, 1'h1, 16'h0300, 1'h0, 3'h5, 1'h0}, '{2'h3, 1'h0, 16'h0200, 1'h1, 3'h0, 1'h1}};
   assign ADC_Y = ADC_X;
   assign ADC_Z = ADC_X;
   msh_top #(.MEAS_LN_TICKS(17'h4), .MEAS_LP_TICKS(17'h3), .CONT_TICKS(17'h6)) u_msh_top (.*);
   msh_host_model u_msh_host_model (.start(go), .burst(burst), .fast(fast),
      .sel_n(SPI_SELECT_N), .sk(SERIAL_CLOCK_IN));
   // --------------------------------------------------------------
   // clock, hang guard, helpers
   // --------------------------------------------------------------
   initial begin
      CLK_SYS = 1'h0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   // ceiling far above the few thousand cycles the run needs
   // pulses launch on the rising edge, so count them on the falling one
   always @(negedge CLK_SYS) begin
      cyc++;
      if (SPI_SAMPLE === 1'h1) edges++;
      if (SPI_SHIFT === 1'h1) shifts++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask : tick
   // bounded: conversion plus repeat gap stays well inside
   task automatic wait_rdy();
      for (int k = 0; k < 800 && DATA_READY !== 1'h1; k++) tick(1);
   endtask : wait_rdy
   task automatic cfg(input logic [1:0] m);
      CFG_MODE = m;
      CFG_WR   = 1'h1;
      tick(1);
      CFG_WR   = 1'h0;
      tick(1);
   endtask : cfg
   task automatic read_ack();
      DATA_READ = 1'h1;
      tick(1);
      DATA_READ = 1'h0;
      tick(1);
   endtask : read_ack
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      {SYS_RST, RESET_N_PIN, ADDR_SELECT_PIN, SO_DATA, SDA_PULL} = 5'h1F;
      {CFG_WR, DATA_READ, CFG_WIDE_RANGE, CFG_LOW_POWER, ADC_OVF, go, burst, fast} = 8'h0;
      {CFG_MODE, CFG_EVENT_SEL, ADC_X} = 20'h0;
      {CFG_THR_X, CFG_THR_Y, CFG_THR_Z} = {16'h0200, 16'h0400, 16'h0200};
      tick(12);
      SYS_RST = 1'h0;
      tick(4);
      chk("mode", 16'h0, MODE_STATE);
      chk("so_oe", 16'h0, SO_OE);
      chk("i2c", 16'h1, I2C_MODE);
      chk("addr", 16'h1, SLAVE_ADDR_SEL);
      chk("sda_oe", 16'h1, SDA_OE);
      chk("sda_o", 16'h0, SDA_O);
      chk("od_o", 16'h0, EVENT_OUT_OPEN_DRAIN_O);
      $display("reset defaults done");
      foreach (rows[i]) begin
         CFG_EVENT_SEL  = rows[i].s;
         CFG_LOW_POWER  = rows[i].l;
         CFG_WIDE_RANGE = !rows[i].l;
         ADC_X          = rows[i].a;
         ADC_OVF        = rows[i].o;
         cfg(2'h1);
         chk("mode", 16'h1, MODE_STATE);
         chk("drive", rows[i].l, LOW_POWER_DRIVE);
         chk("range", !rows[i].l, WIDE_RANGE);
         tick(1);
         chk("on", 16'h1, SENSOR_ON);
         wait_rdy();
         tick(2);
         chk("ready", 16'h1, DATA_READY);
         chk("on", 16'h0, SENSOR_ON);
         chk("meas", rows[i].a, MEAS_Z);
         chk("meas_x", rows[i].a, MEAS_X);
         chk("meas_y", rows[i].a, MEAS_Y);
         chk("switch", rows[i].w, SWITCH_BITS);
         chk("thr", |rows[i].w, THRESHOLD_STATE);
         chk("ovf", rows[i].o, OVERFLOW);
         chk("mode", 16'h0, MODE_STATE);
         chk("event", rows[i].e, EVENT_OUT);
         chk("od_oe", rows[i].e, EVENT_OUT_OPEN_DRAIN_OE);
         read_ack();
         chk("ready", 16'h0, DATA_READY);
         $display("row %0d done", i);
      end
      RESET_N_PIN = 1'h0;
      tick(4);
      chk("meas", 16'h0, MEAS_Z);
      chk("ovf", 16'h0, OVERFLOW);
      RESET_N_PIN = 1'h1;
      tick(4);
      cfg(2'h2);
      wait_rdy();
      read_ack();
      wait_rdy();
      chk("ready", 16'h1, DATA_READY);
      chk("mode", 16'h2, MODE_STATE);
      cfg(2'h0);
      $display("reset pin and continuous done");
      ADDR_SELECT_PIN = 1'h0;
      go = 1'h1;
      tick(8);
      chk("so_oe", 16'h1, SO_OE);
      chk("so", 16'h1, SO_O);
      chk("i2c", 16'h0, I2C_MODE);
      chk("addr", 16'h0, SLAVE_ADDR_SEL);
      chk("sda_oe", 16'h0, SDA_OE);
      go = 1'h0;
      tick(120);
      chk("samples", 16'h8, 16'(edges));
      chk("shifts", 16'h8, 16'(shifts));
      chk("so_oe", 16'h0, SO_OE);
      $display("four-wire frame done");
      // two-wire clock at about 400 kHz, then at about 83 kHz
      fast  = 1'h1;
      burst = 1'h1;
      tick(220);
      chk("fast", 16'h1, BUS_FAST);
      {fast, burst} = 2'h0;
      tick(1);
      burst = 1'h1;
      tick(950);
      chk("fast", 16'h0, BUS_FAST);
      burst = 1'h0;
      $display("two-wire speed done");
      conclude();
   end
endmodule : tb_msh_top
